// [src/dacw_defines.svh]
`ifndef DACW_DEFINES_SVH
`define DACW_DEFINES_SVH
// Overview of operation
// - Slave only; acknowledges and moves bytes solely under master control.
// - Both lines are only pulled low or released; idle reads high.
// - SDA stable while SCL high; changes only while SCL low.
// - First byte compared with 100110 plus select pin; bit 0 is direction.
// - On address match, SDA held low through ninth pulse high phase.
// - Receiver pulls SDA low on ninth pulse; transmitter releases it.
// - SDA high through the ninth pulse means not-acknowledge.
// - Direction 0 receives write bytes; direction 1 transmits contents.
// - First write byte after address is the acknowledged control byte.
// - Next byte latched as upper eight bits, acknowledged.
// - Following byte latched as lower eight bits, acknowledged.
// - Word loaded at SCL fall ending the ack after the low byte.
// - Further high/low pairs allowed; each pair gives a new update.
// - After stop, ignore traffic until start plus own address.
// - Stop leaves conversion word and mode unchanged.
// - Word is unsigned binary code 0 to 65535.
// - Works at 100 kbps, 400 kbps and 3.4 Mbps.
// - Power-down flag set: high byte bits 7..5 carry power-down setting.

// Slave address, upper six bits; lowest comes from the select pin
`define DACW_ADDR_HI    6'h26
`define DACW_BIT_LAST   4'h7
`define DACW_ACK_SLOT   4'h8
`define DACW_CNT_FIRST  4'h1
`define DACW_CNT_ZERO   4'h0
`define DACW_CNT_ONE    4'h1
// Read order index: high byte, low byte, control byte
`define DACW_RD_HI      2'h0
`define DACW_RD_LO      2'h1
`define DACW_RD_CTRL    2'h2
`define DACW_CODE_RST   16'h0000
`define DACW_CTRL_RST   8'h00
`define DACW_PD_FLAG    0
`endif

// [src/dacw_pkg.sv]
package dacw_pkg;
  typedef enum logic [5:0] {
    DACW_ST_IDLE = 6'h01,
    DACW_ST_ADDR = 6'h02,
    DACW_ST_CTRL = 6'h04,
    DACW_ST_HI   = 6'h08,
    DACW_ST_LO   = 6'h10,
    DACW_ST_READ = 6'h20
  } dacw_state_t;

  typedef struct packed {
    logic [15:0] code;
    logic [7:0]  ctrl;
  } dacw_out_t;
endpackage

// [src/dacw_i2c_slave.sv]
`timescale 1ns/100ps
`include "dacw_defines.svh"
module dacw_i2c_slave (
  input  wire logic            clk_sys,         // System clock, 40 MHz
  input  wire logic            rst,             // Async reset, active high
  input  wire logic            scl_i,           // Bus clock, link domain
  input  wire logic            sda_i,           // Bus data level
  output logic                 sda_o,           // Data drive value, always 0
  output logic                 sda_oe_n,        // Low while pulling SDA low
  input  wire logic            addr_select_pin, // Address bit 0 strap
  output dacw_pkg::dacw_out_t  dac_out,         // Converter word and mode
  output logic                 power_down_flag, // Mode bit 0 of control
  output logic                 dac_update       // One-cycle update pulse
);
  import dacw_pkg::*;

  // -------------------------------------------------------------
  // Start and stop detection
  // -------------------------------------------------------------
  // Toggles flip on SDA edges while SCL is high. The SCL domain
  // reads them only at the next SCL rise, which by bus timing comes
  // long after the toggle settled, so they act as quasi-static.
  logic start_tgl_q;
  logic stop_tgl_q;

  always_ff @(negedge sda_i or posedge rst) begin
    if (rst) begin
      start_tgl_q <= 1'b0;
    end else if (scl_i) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  always_ff @(posedge sda_i or posedge rst) begin
    if (rst) begin
      stop_tgl_q <= 1'b0;
    end else if (scl_i) begin
      stop_tgl_q <= ~stop_tgl_q;
    end
  end

  // -------------------------------------------------------------
  // Link domain: byte engine on SCL rise
  // -------------------------------------------------------------
  // Everything here runs on SCL itself, so it keeps up with any
  // bus rate the master chooses.
  dacw_state_t st_q;
  dacw_state_t st_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic [6:0]  sh_q;
  logic        ack_q;
  logic        ack_d;
  logic        lo_done_q;
  logic        upd_q;
  logic        upd_d;
  logic [1:0]  rd_idx_q;
  logic [7:0]  tx_q;
  logic [7:0]  tx_byte;
  logic [7:0]  ctrl_q;
  logic [7:0]  hi_q;
  logic [7:0]  lo_q;
  logic        start_seen_q;
  logic        stop_seen_q;
  logic        a0_m_q;
  logic        a0_q;
  logic [15:0] dac_q;
  logic        dac_tgl_q;
  logic        sda_oe_n_q;

  wire         new_start = start_tgl_q != start_seen_q;
  wire         new_stop  = stop_tgl_q != stop_seen_q;
  wire         byte_end  = cnt_q == `DACW_BIT_LAST;
  wire         ack_clk   = cnt_q == `DACW_ACK_SLOT;
  wire [7:0]   byte_w    = {sh_q, sda_i};
  wire         addr_hit  = byte_w[7:1] == {`DACW_ADDR_HI, a0_q};
  wire         is_rx     = st_q == DACW_ST_CTRL || st_q == DACW_ST_HI
                           || st_q == DACW_ST_LO;

  assign tx_byte = (rd_idx_q == `DACW_RD_HI) ? dac_q[15:8] :
                   (rd_idx_q == `DACW_RD_LO) ? dac_q[7:0]  :
                   (rd_idx_q == `DACW_RD_CTRL) ? ctrl_q : dac_q[15:8];

  assign cnt_d = new_start ? `DACW_CNT_FIRST :
                 ack_clk   ? `DACW_CNT_ZERO  :
                 cnt_q + `DACW_CNT_ONE;

  // Only a matched address or a received write byte is acknowledged;
  // a stop seen with the last bit cancels the ack
  assign ack_d = !byte_end ? ack_q :
                 !new_stop && ((st_q == DACW_ST_ADDR && addr_hit)
                               || is_rx);

  // Update armed by the ack slot that follows the low byte
  assign upd_d = ack_clk && lo_done_q && !new_start;

  always_comb begin
    st_d = st_q;
    if (new_start) begin
      st_d = DACW_ST_ADDR;
    end else if (new_stop) begin
      st_d = DACW_ST_IDLE;
    end else if (byte_end) begin
      unique case (st_q)
        DACW_ST_IDLE: st_d = DACW_ST_IDLE;
        DACW_ST_ADDR: st_d = !addr_hit ? DACW_ST_IDLE :
                             byte_w[0] ? DACW_ST_READ :
                             DACW_ST_CTRL;
        DACW_ST_CTRL: st_d = DACW_ST_HI;
        DACW_ST_HI:   st_d = DACW_ST_LO;
        DACW_ST_LO:   st_d = DACW_ST_HI;
        DACW_ST_READ: st_d = DACW_ST_READ;
        default:      st_d = DACW_ST_IDLE;
      endcase
    end else if (ack_clk && st_q == DACW_ST_READ && sda_i) begin
      st_d = DACW_ST_IDLE;
    end
  end

  // Strap is sampled on SCL, so a change of the select pin takes
  // two bus clocks; change it only while the bus is idle.
  always_ff @(posedge scl_i or posedge rst) begin
    if (rst) begin
      st_q         <= DACW_ST_IDLE;
      cnt_q        <= `DACW_CNT_ZERO;
      sh_q         <= 7'h00;
      ack_q        <= 1'b0;
      lo_done_q    <= 1'b0;
      upd_q        <= 1'b0;
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
      a0_m_q       <= 1'b0;
      a0_q         <= 1'b0;
    end else begin
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      sh_q         <= byte_w[6:0];
      ack_q        <= ack_d;
      upd_q        <= upd_d;
      start_seen_q <= start_tgl_q;
      stop_seen_q  <= stop_tgl_q;
      a0_m_q       <= addr_select_pin;
      a0_q         <= a0_m_q;
      if (new_start || byte_end) begin
        lo_done_q <= byte_end && !new_start && st_q == DACW_ST_LO;
      end
    end
  end

  // Data bytes and read pointer. Our own address ack also pulls
  // SDA low, so the pointer moves only in a slot we left released.
  always_ff @(posedge scl_i or posedge rst) begin
    if (rst) begin
      ctrl_q   <= `DACW_CTRL_RST;
      hi_q     <= 8'h00;
      lo_q     <= 8'h00;
      rd_idx_q <= `DACW_RD_HI;
      tx_q     <= 8'hff;
    end else if (byte_end && !new_start) begin
      if (st_q == DACW_ST_CTRL) ctrl_q <= byte_w;
      if (st_q == DACW_ST_HI) hi_q <= byte_w;
      if (st_q == DACW_ST_LO) lo_q <= byte_w;
      if (st_q == DACW_ST_ADDR) begin
        rd_idx_q <= `DACW_RD_LO;
        tx_q     <= dac_q[15:8];
      end
    end else if (ack_clk && st_q == DACW_ST_READ && !ack_q && !sda_i) begin
      rd_idx_q <= (rd_idx_q == `DACW_RD_CTRL) ? `DACW_RD_HI
                                               : rd_idx_q + 2'h1;
      tx_q     <= tx_byte;
    end
  end

  // -------------------------------------------------------------
  // Link domain: SDA drive and word load on SCL fall
  // -------------------------------------------------------------
  // Changing SDA only on the fall keeps it steady through SCL high.
  wire drive_n = ack_clk ? ~ack_q :
                 (st_q == DACW_ST_READ) ? tx_q[~cnt_q[2:0]] :
                 1'b1;

  always_ff @(negedge scl_i or posedge rst) begin
    if (rst) begin
      sda_oe_n_q <= 1'b1;
      dac_q      <= `DACW_CODE_RST;
      dac_tgl_q  <= 1'b0;
    end else begin
      sda_oe_n_q <= drive_n;
      if (upd_q) begin
        dac_q     <= {hi_q, lo_q};
        dac_tgl_q <= ~dac_tgl_q;
      end
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_n = sda_oe_n_q;

  // -------------------------------------------------------------
  // System domain: take the word on each update
  // -------------------------------------------------------------
  // Word and control are stable long after the toggle moves, so
  // only the toggle needs the two-stage synchroniser.
  logic       upd_m_q;
  logic       upd_s_q;
  logic       upd_p_q;
  dacw_out_t  out_q;
  logic       pd_q;
  logic       pulse_q;
  wire        upd_evt = upd_s_q ^ upd_p_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      upd_m_q <= 1'b0;
      upd_s_q <= 1'b0;
      upd_p_q <= 1'b0;
      out_q   <= '{code: `DACW_CODE_RST, ctrl: `DACW_CTRL_RST};
      pd_q    <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      upd_m_q <= dac_tgl_q;
      upd_s_q <= upd_m_q;
      upd_p_q <= upd_s_q;
      pulse_q <= upd_evt;
      if (upd_evt) begin
        out_q <= '{code: dac_q, ctrl: ctrl_q};
        pd_q  <= ctrl_q[`DACW_PD_FLAG];
      end
    end
  end

  assign dac_out         = out_q;
  assign power_down_flag = pd_q;
  assign dac_update      = pulse_q;

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  // Link checks sample on SCL; output checks run on clk_sys
  AST_ACK_MATCH: assert property (
    @(posedge scl_i) disable iff (rst)
    (byte_end && !new_start && st_q == DACW_ST_ADDR && addr_hit)
    |=> ack_clk && !sda_oe_n_q)
    else $error("matched address not acknowledged");
  AST_NO_ACK_MISS: assert property (
    @(posedge scl_i) disable iff (rst)
    (byte_end && !new_start && st_q == DACW_ST_ADDR && !addr_hit)
    |=> st_q == DACW_ST_IDLE && sda_oe_n_q)
    else $error("mismatched address drove SDA");
  AST_IDLE_SILENT: assert property (
    @(posedge scl_i) disable iff (rst)
    (st_q == DACW_ST_IDLE) |-> sda_oe_n_q)
    else $error("idle engine drove SDA");
  AST_START_RESTART: assert property (
    @(posedge scl_i) disable iff (rst)
    new_start |=> st_q == DACW_ST_ADDR && cnt_q == 4'h1)
    else $error("start did not restart address phase");
  AST_WRITE_ORDER: assert property (
    @(posedge scl_i) disable iff (rst)
    (byte_end && !new_start && !new_stop && st_q == DACW_ST_CTRL)
    |=> st_q == DACW_ST_HI && ctrl_q == $past(byte_w))
    else $error("control byte not taken");
  AST_PAIR_LOOP: assert property (
    @(posedge scl_i) disable iff (rst)
    (byte_end && !new_start && !new_stop && st_q == DACW_ST_LO)
    |=> st_q == DACW_ST_HI ##1 upd_q)
    else $error("low byte did not arm update");
  AST_LOAD_WORD: assert property (
    @(negedge scl_i) disable iff (rst)
    upd_q |=> dac_q == $past({hi_q, lo_q}))
    else $error("word not loaded on ack fall");
  AST_READ_RELEASE: assert property (
    @(posedge scl_i) disable iff (rst)
    (st_q == DACW_ST_READ && ack_clk && !ack_q) |-> sda_oe_n_q)
    else $error("transmitter held SDA in master ack slot");
  AST_OUT_STEADY: assert property (
    @(posedge clk_sys) disable iff (rst)
    !$past(upd_evt) |-> $stable(dac_out))
    else $error("output word moved without update");
  AST_RX_ACK: assert property (
    @(posedge scl_i) disable iff (rst)
    (byte_end && !new_start && !new_stop && is_rx)
    |=> ack_clk && !sda_oe_n_q)
    else $error("write byte not acknowledged");
  AST_NACK_END: assert property (
    @(posedge scl_i) disable iff (rst)
    (ack_clk && st_q == DACW_ST_READ && sda_i && !new_start && !new_stop)
    |=> st_q == DACW_ST_IDLE && sda_oe_n_q)
    else $error("not-acknowledge did not end the read");
  AST_READ_FIRST: assert property (
    @(posedge scl_i) disable iff (rst)
    (byte_end && !new_start && !new_stop && st_q == DACW_ST_ADDR
     && addr_hit && byte_w[0]) |=> ##1 tx_q == dac_q[15:8])
    else $error("read did not open with the high byte");
  AST_ONE_PULSE: assert property (
    @(posedge clk_sys) disable iff (rst)
    dac_update |=> !dac_update)
    else $error("update pulse longer than one cycle");
  AST_WORD_CROSS: assert property (
    @(posedge clk_sys) disable iff (rst)
    dac_update |-> dac_out.code == dac_q && dac_out.ctrl == ctrl_q)
    else $error("word changed while crossing domains");
endmodule

// [bench/dacw_master.sv]
`timescale 1ns/100ps
module dacw_master (
  output logic      scl,      // Bus clock, stands high outside frames
  output logic      sda_pull, // High while the master pulls SDA low
  input  wire logic sda       // Resolved data line
);
  // ------------------------------------------------------------
  // Bus master, 12 ns clock period
  // ------------------------------------------------------------
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Start or repeated start
  task automatic start();
    if (scl === 1'b0) begin
      #2 sda_pull = 1'b0;
      #4 scl = 1'b1;
      #3;
    end
    sda_pull = 1'b1;
    #3 scl = 1'b0;
  endtask

  // SDA rises while SCL high, bus back to idle
  task automatic stop();
    #2 sda_pull = 1'b1;
    #4 scl = 1'b1;
    #3 sda_pull = 1'b0;
    #6;
  endtask

  // Byte and ack slot; tx of ff releases SDA for reading
  task automatic byte_io(input  logic [7:0] tx,
                         input  logic       m_ack,
                         output logic [7:0] rx,
                         output logic       ack);
    for (int i = 7; i >= 0; i--) begin
      #2 sda_pull = ~tx[i];
      #4 scl = 1'b1;
      #3 rx[i] = sda;
      #3 scl = 1'b0;
    end
    #2 sda_pull = m_ack;
    #4 scl = 1'b1;
    #3 ack = ~sda;
    #3 scl = 1'b0;
  endtask
endmodule

// [bench/dacw_i2c_slave_bench.sv]
`timescale 1ns/100ps
module dacw_i2c_slave_bench;
  import dacw_pkg::*;
  logic        clk_sys;
  logic        rst;
  logic        scl;
  logic        sda;
  logic        sda_pull;
  logic        sda_o;
  logic        sda_oe_n;
  logic        addr_select_pin;
  dacw_out_t   dac_out;
  logic        power_down_flag;
  logic        dac_update;
  logic [31:0] seed;
  logic [24:0] exp_q[$];
  int          fails;
  int          tests_run;
  logic [15:0] word;
  logic [7:0]  ctrl;
  logic [7:0]  rx;
  logic        ack;

  // Open-drain line with pull-up
  assign sda = sda_pull ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);

  dacw_i2c_slave u_dacw_i2c_slave (.clk_sys(clk_sys), .rst(rst),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .addr_select_pin(addr_select_pin), .dac_out(dac_out),
    .power_down_flag(power_down_flag), .dac_update(dac_update));
  dacw_master u_dacw_master (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic put(input logic [7:0] b, input logic exp_ack);
    u_dacw_master.byte_io(b, 1'b0, rx, ack);
    check(ack, exp_ack);
  endtask

  // Bounded wait for every noted update to show
  task automatic drain();
    for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(posedge clk_sys);
    if (exp_q.size() != 0) begin
      fails++;
      results();
    end
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic write_frame(input logic [7:0] c, input int pairs,
                             input logic lone_hi);
    logic [15:0] w;
    u_dacw_master.start();
    put({6'h26, addr_select_pin, 1'b0}, 1'b1);
    put(c, 1'b1);
    ctrl = c;
    for (int p = 0; p < pairs; p++) begin
      seed = xorshift(seed);
      w = (p == 0) ? 16'hffff : (p == 1) ? 16'h0000 : seed[15:0];
      if (c[0]) w = {seed[7:5], 13'h0000};
      exp_q.push_back({w, c, c[0]});
      put(w[15:8], 1'b1);
      put(w[7:0], 1'b1);
      word = w;
    end
    if (lone_hi) put(seed[23:16], 1'b1);
    u_dacw_master.stop();
    drain();
  endtask

  task automatic read_frame();
    u_dacw_master.start();
    put({6'h26, addr_select_pin, 1'b1}, 1'b1);
    u_dacw_master.byte_io(8'hff, 1'b1, rx, ack);
    check(rx, word[15:8]);
    u_dacw_master.byte_io(8'hff, 1'b1, rx, ack);
    check(rx, word[7:0]);
    u_dacw_master.byte_io(8'hff, 1'b0, rx, ack);
    check(rx, ctrl);
    u_dacw_master.stop();
  endtask

  // ------------------------------------------------------------
  // Clock, result watcher, sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Settled values are looked at away from the launching edge
  always @(negedge clk_sys) begin
    if (dac_update === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        check({dac_out, power_down_flag}, exp_q.pop_front());
      end
    end
  end

  initial begin
    rst             = 1'b1;
    fails           = 0;
    tests_run       = 0;
    seed            = 32'he9be3ac8;
    addr_select_pin = 1'b0;
    word            = 16'h0000;
    ctrl            = 8'h00;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    check({dac_out, power_down_flag, sda_oe_n, sda_o}, 27'h2);
    for (int k = 0; k < 4; k++) begin
      seed = xorshift(seed);
      @(negedge clk_sys) addr_select_pin = seed[8];
      write_frame({seed[7:1], 1'b0}, 3, 1'b0);
      read_frame();
    end
    // Stop in mid-pair keeps the old word
    write_frame(ctrl, 0, 1'b1);
    check(dac_out, {word, ctrl});
    // Foreign address is ignored until the next start
    u_dacw_master.start();
    put({6'h26, ~addr_select_pin, 1'b0}, 1'b0);
    put(8'h55, 1'b0);
    write_frame(8'h01, 2, 1'b0);
    check(power_down_flag, 1'b1);
    read_frame();
    results();
  end
endmodule
